//--- dv/dot_pins_model.sv
// Model of the terminal side: input pins, controller claims, card slot.
// Assumes the bench calls its tasks right after a rising clock edge.
module dot_pins_model #(
   parameter logic [2:0] CARD = 3'h5 // Arbitrary card code
) (
   input  wire logic        sys_clk_i,
   output logic      [15:0] pins_o,
   output logic      [15:0] claim_in_o,
   output logic      [15:0] claim_out_o,
   output logic      [2:0]  card_o
);
   // Idle levels; counting input low
   initial begin
      pins_o = 16'h0014;
      claim_in_o = 16'h0034;
      claim_out_o = 16'h0003;
      card_o = CARD;
   end
   // Set all input levels
   task automatic drive(input logic [15:0] v);
      pins_o <= v;
   endtask
   // Pulses held long enough to pass the pin synchronisers
   task automatic pulse(input int n);
      for (int i = 0; i < n; i++) begin
         pins_o[5] <= 1'b1;
         repeat (4) @(posedge sys_clk_i);
         pins_o[5] <= 1'b0;
         repeat (4) @(posedge sys_clk_i);
      end
   endtask
endmodule

//--- dv/dot_terminal_assertions.sv
// Checker for the drive output terminal logic, bound to its top module.
// Assumes one clock domain with an asynchronous active-high reset.
module dot_terminal_chk (
   input wire logic        sys_clk_i,
   input wire logic        reset_i,
   input wire logic [7:0]  avs_address_i,
   input wire logic        avs_read_i,
   input wire logic        avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic        avs_waitrequest_o,
   input wire logic        run_i,
   input wire logic [15:0] configurable_input_i,
   input wire logic [2:0]  card_code_i,
   input wire logic [15:0] terminal_o,
   input wire logic        preheat_on_o,
   input wire logic [6:0]  preheat_level_o
);
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (reset_i);
   // Read taken at an edge; pins must be steady across the two sync stages
   logic rd_take;
   assign rd_take = avs_read_i && avs_waitrequest_o;
   a_reserved_low: assert property (terminal_o[4:3] == 2'h0)
      else $error("reserved terminal bits driven");
   a_wait_answer: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o) else $error("access not answered next cycle");
   a_wait_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
      else $error("waitrequest low too long");
   a_upper_zero: assert property (rd_take && avs_address_i < 8'h80
      |=> avs_readdata_o[31:16] == 16'h0) else $error("upper half not zero");
   a_card_code: assert property (rd_take && avs_address_i == dot_pkg::OFS_CARD_ID
      && $stable(card_code_i) && card_code_i == $past(card_code_i, 2)
      && card_code_i == $past(card_code_i, 3)
      |=> avs_readdata_o == {29'h0, $past(card_code_i)}) else $error("card code wrong");
   a_input_state: assert property (rd_take && avs_address_i == dot_pkg::OFS_IN_STATE
      && $stable(configurable_input_i)
      && configurable_input_i == $past(configurable_input_i, 2)
      && configurable_input_i == $past(configurable_input_i, 3)
      |=> avs_readdata_o == {16'h0, $past(configurable_input_i)})
      else $error("input state wrong");
   a_heat_idle: assert property (!preheat_on_o |-> preheat_level_o == 7'h0)
      else $error("level without preheat");
   a_heat_level: assert property (preheat_on_o |-> preheat_level_o != 7'h0)
      else $error("preheat with zero level");
   a_run_blocks: assert property (run_i && $past(run_i) && $past(run_i, 2)
      && $past(run_i, 3) |-> !preheat_on_o) else $error("preheat while running");
   c_heat_on: cover property ($rose(preheat_on_o));
   c_write: cover property (avs_write_i && !avs_waitrequest_o);
   c_card: cover property (rd_take && avs_address_i == dot_pkg::OFS_CARD_ID);
endmodule

bind dot_terminal dot_terminal_chk u_chk (
   .sys_clk_i(sys_clk_i), .reset_i(reset_i), .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
   .avs_waitrequest_o(avs_waitrequest_o), .run_i(run_i),
   .configurable_input_i(configurable_input_i), .card_code_i(card_code_i),
   .terminal_o(terminal_o), .preheat_on_o(preheat_on_o), .preheat_level_o(preheat_level_o));

//--- dv/tb.sv
// Self-checking bench for the drive output terminal logic.
// Assumes the pin model on the terminal side and a shortened tick.
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TK = 2;
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic [7:0]  adr = 8'h00;
   logic        rd = 1'b0;
   logic        wr = 1'b0;
   logic [31:0] wd = 32'h0;
   logic        run = 1'b0;
   logic        flt = 1'b0;
   logic        uv = 1'b0;
   logic        ext = 1'b0;
   logic        frst = 1'b0;
   logic        fterm = 1'b0;
   logic [15:0] fcmd = 16'h0;
   logic [15:0] ofrq = 16'h0;
   logic [7:0]  ocur = 8'h0;
   logic [31:0] rdat, q;
   logic        wreq, ast, hon;
   logic [15:0] pins, cin, cout, term;
   logic [2:0]  card;
   logic [6:0]  hlvl;
   int          mismatches = 0;
   int          tests_run = 0;
   // Clock at 200 MHz
   initial forever #2.5 clk = ~clk;
   dot_pins_model #(.CARD(3'h5)) pm (.sys_clk_i(clk), .pins_o(pins), .claim_in_o(cin),
      .claim_out_o(cout), .card_o(card));
   dot_terminal #(.TICK_CYC(TK)) DUT (.sys_clk_i(clk), .reset_i(rst), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hf),
      .avs_readdata_o(rdat), .avs_waitrequest_o(wreq), .run_i(run), .fault_i(flt),
      .undervoltage_state_i(uv), .fault_reset_i(frst), .ext_run_cmd_i(ext),
      .freq_from_terminal_i(fterm), .freq_cmd_i(fcmd), .out_freq_i(ofrq),
      .out_current_i(ocur), .configurable_input_i(pins), .claimed_in_i(cin),
      .claimed_out_i(cout), .card_code_i(card), .terminal_o(term), .auto_start_o(ast),
      .preheat_on_o(hon), .preheat_level_o(hlvl));
   task automatic give_verdict();
      if (mismatches == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic chk_w(input string n, input logic [31:0] e, input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, e, g);
      end
   endtask
   // One bus access; an edge passes after release before the next
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      adr <= a;
      wr <= w;
      rd <= !w;
      wd <= d;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 40);
      q = rdat;
      rd <= 1'b0;
      wr <= 1'b0;
      @(posedge clk);
      if (n >= 40) begin
         mismatches++;
         give_verdict();
      end
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic wait_hon(input int lim);
      int n;
      n = 0;
      while (hon !== 1'b1 && n < lim) begin
         @(posedge clk);
         n++;
      end
      if (n >= lim) begin
         mismatches++;
         give_verdict();
      end
   endtask
   task automatic t_reset();
      xfer(0, dot_pkg::OFS_POLARITY, 0);
      chk_w("polarity", {16'h0, dot_pkg::RST_POLARITY}, q);
      xfer(0, dot_pkg::OFS_FREQ_BND, 0);
      chk_w("boundary", {16'h0, dot_pkg::RST_FREQ_BND}, q);
      xfer(0, dot_pkg::OFS_CARD_ID, 0);
      chk_w("card", 32'h5, q);
      xfer(0, dot_pkg::OFS_CLAIM_IN, 0);
      chk_w("claim_in", 32'h34, q);
      xfer(0, dot_pkg::OFS_CLAIM_OUT, 0);
      chk_w("claim_out", 32'h3, q);
      xfer(1, dot_pkg::OFS_IN_STATE, 32'hffff);
      xfer(0, dot_pkg::OFS_IN_STATE, 0);
      chk_w("in_state", 32'h14, q);
      xfer(0, 8'h50, 0);
      chk_w("unmapped", 32'h0, q);
   endtask
   task automatic t_compare();
      xfer(1, dot_pkg::OFS_FUNC_BASE, {25'h0, dot_pkg::FN_CUR_HI});
      xfer(1, dot_pkg::OFS_FUNC_BASE + 8'h04, {25'h0, dot_pkg::FN_CUR_LO});
      xfer(1, dot_pkg::OFS_FUNC_BASE + 8'h14, {25'h0, dot_pkg::FN_FRQ_HI});
      xfer(1, dot_pkg::OFS_FUNC_BASE + 8'h18, {25'h0, dot_pkg::FN_FRQ_LO});
      xfer(1, dot_pkg::OFS_FUNC_BASE + 8'h28, {25'h0, dot_pkg::FN_FREQ1});
      xfer(1, dot_pkg::OFS_CUR_THR, 32'h32);
      ocur <= 8'h32;
      ofrq <= dot_pkg::RST_FREQ_BND;
      tk(4);
      chk_w("at_limits", 32'h21, {16'h0, term & 16'h0063});
      ocur <= 8'h31;
      ofrq <= dot_pkg::RST_FREQ_BND - 16'h1;
      tk(4);
      chk_w("below", 32'h42, {16'h0, term & 16'h0063});
      xfer(1, dot_pkg::OFS_POLARITY, 32'hffff);
      tk(3);
      chk_w("inverted", 32'hfba5, {16'h0, term});
      xfer(0, dot_pkg::OFS_OUT_STATE, 0);
      chk_w("out_state", 32'h442, q);
      xfer(1, dot_pkg::OFS_POLARITY, 0);
      ofrq <= dot_pkg::RST_TGT_FREQ + dot_pkg::RST_WIDTH;
      tk(4);
      chk_w("attained", 32'h0, {31'h0, term[10]});
   endtask
   task automatic t_count();
      xfer(1, dot_pkg::OFS_FINAL_CNT, 32'h3);
      xfer(1, dot_pkg::OFS_PRELIM_CNT, 32'h2);
      xfer(1, dot_pkg::OFS_FINAL_CNT, 32'h0);
      xfer(0, dot_pkg::OFS_FINAL_CNT, 0);
      chk_w("final", 32'h3, q);
      xfer(1, dot_pkg::OFS_FUNC_BASE + 8'h1c, {25'h0, dot_pkg::FN_PRELIM});
      xfer(1, dot_pkg::OFS_FUNC_BASE + 8'h2c, {25'h0, dot_pkg::FN_FINAL});
      pm.pulse(2);
      tk(4);
      xfer(0, dot_pkg::OFS_COUNT, 0);
      chk_w("count", 32'h2, q);
      xfer(0, dot_pkg::OFS_OUT_STATE, 0);
      chk_w("prelim", 32'h1, {31'h0, q[7]});
      pm.pulse(1);
      tk(4);
      xfer(0, dot_pkg::OFS_COUNT, 0);
      chk_w("wrap", 32'h0, q);
      xfer(0, dot_pkg::OFS_OUT_STATE, 0);
      chk_w("final_out", 32'h800, q & 32'h880);
   endtask
   task automatic t_held();
      fterm <= 1'b1;
      fcmd <= 16'h1388;
      uv <= 1'b1;
      tk(4);
      uv <= 1'b0;
      fcmd <= 16'h0;
      tk(4);
      xfer(0, dot_pkg::OFS_HELD_FREQ, 0);
      chk_w("held", 32'h1388, q);
   endtask
   task automatic t_brake();
      xfer(1, dot_pkg::OFS_FUNC_BASE + 8'h20, {25'h0, dot_pkg::FN_BRAKE});
      xfer(1, dot_pkg::OFS_BRAKE_DLY, 32'h5);
      {run, ext} <= 2'h3;
      tk(20);
      chk_w("no_dc", 32'h2, {30'h0, term[8], ast});
      xfer(1, dot_pkg::OFS_CONTROL, 32'h3);
      tk(2);
      chk_w("brake_wait", 32'h2, {30'h0, term[8], ast});
      frst <= 1'b1;
      tk(20);
      chk_w("brake_rel", 32'h1, {30'h0, term[8], ast});
      {run, ext, frst} <= 3'h0;
   endtask
   task automatic t_heat();
      int offc;
      offc = 50 * dot_pkg::HEAT_STEP_MS * TK;
      run <= 1'b1;
      xfer(1, dot_pkg::OFS_FUNC_BASE + 8'h24, {25'h0, dot_pkg::FN_HEAT});
      xfer(1, dot_pkg::OFS_PREHEAT_LVL, 32'h28);
      xfer(1, dot_pkg::OFS_PREHEAT_CYC, 32'h32);
      tk(4);
      chk_w("run_heat", 32'h0, {31'h0, hon});
      run <= 1'b0;
      tk(offc * 9 / 10);
      chk_w("off_phase", 32'h0, {31'h0, hon});
      wait_hon(offc / 5);
      tk(3);
      chk_w("level", 32'h28, {25'h0, hlvl});
      chk_w("heat_term", 32'h1, {31'h0, term[9]});
      run <= 1'b1;
      xfer(1, dot_pkg::OFS_PREHEAT_CYC, 32'h0);
      tk(4);
      chk_w("run_off", 32'h0, {30'h0, hon, term[9]});
      run <= 1'b0;
      tk(4);
      xfer(1, dot_pkg::OFS_PREHEAT_CYC, 32'h64);
      tk(2000);
      chk_w("zero_cyc", 32'h0, {31'h0, hon});
      xfer(1, dot_pkg::OFS_FUNC_BASE + 8'h08, 32'h0001_0000);
      pm.drive(16'h0014);
      wait_hon(2000);
      chk_w("input_heat", 32'h1, {31'h0, hon});
      flt <= 1'b1;
      tk(4);
      chk_w("fault_off", 32'h0, {31'h0, hon});
   endtask
   // Reset, then the scenarios in turn
   initial begin
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_compare();
      t_count();
      t_held();
      t_brake();
      t_heat();
      give_verdict();
   end
endmodule

//--- shared/dot_pkg.sv
// Constants for the drive output terminal logic: register map, fields, function codes, timing.
// Assumes a 200 MHz system clock and a 32-bit Avalon-MM slave with word addressing in bytes.
package dot_pkg;
   // Register byte offsets
   localparam logic [7:0] OFS_POLARITY    = 8'h00;
   localparam logic [7:0] OFS_FINAL_CNT   = 8'h04;
   localparam logic [7:0] OFS_PRELIM_CNT  = 8'h08;
   localparam logic [7:0] OFS_TGT_FREQ1   = 8'h0c;
   localparam logic [7:0] OFS_TGT_FREQ2   = 8'h10;
   localparam logic [7:0] OFS_WIDTH1      = 8'h14;
   localparam logic [7:0] OFS_WIDTH2      = 8'h18;
   localparam logic [7:0] OFS_BRAKE_DLY   = 8'h1c;
   localparam logic [7:0] OFS_CUR_THR     = 8'h20;
   localparam logic [7:0] OFS_FREQ_BND    = 8'h24;
   localparam logic [7:0] OFS_CONTROL     = 8'h28;
   localparam logic [7:0] OFS_PREHEAT_LVL = 8'h2c;
   localparam logic [7:0] OFS_PREHEAT_CYC = 8'h30;
   localparam logic [7:0] OFS_IN_STATE    = 8'h34;
   localparam logic [7:0] OFS_OUT_STATE   = 8'h38;
   localparam logic [7:0] OFS_CLAIM_IN    = 8'h3c;
   localparam logic [7:0] OFS_CLAIM_OUT   = 8'h40;
   localparam logic [7:0] OFS_HELD_FREQ   = 8'h44;
   localparam logic [7:0] OFS_CARD_ID     = 8'h48;
   localparam logic [7:0] OFS_COUNT       = 8'h4c;
   localparam logic [7:0] OFS_FUNC_BASE   = 8'h80; // 16 selectors, one word each
   // Reset values
   localparam logic [15:0] RST_POLARITY   = 16'h0000;
   localparam logic [15:0] RST_FINAL_CNT  = 16'h0000;
   localparam logic [15:0] RST_TGT_FREQ   = 16'h1770; // 60.00 Hz in 0.01 Hz
   localparam logic [15:0] RST_WIDTH      = 16'h00c8; // 2.00 Hz
   localparam logic [15:0] RST_FREQ_BND   = 16'h012c; // 3.00 Hz
   localparam logic [15:0] RST_ZERO       = 16'h0000;
   // Fields
   localparam int CTL_AUTOSTART = 0;
   localparam int CTL_DCBRAKE   = 1;
   localparam logic [15:0] RESERVED_BITS = 16'h0018;
   // Function codes
   localparam logic [6:0] FN_FREQ1  = 7'h03;
   localparam logic [6:0] FN_FREQ2  = 7'h04;
   localparam logic [6:0] FN_BRAKE  = 7'h0c;
   localparam logic [6:0] FN_PRELIM = 7'h11;
   localparam logic [6:0] FN_FINAL  = 7'h12;
   localparam logic [6:0] FN_CUR_HI = 7'h1b;
   localparam logic [6:0] FN_CUR_LO = 7'h1c;
   localparam logic [6:0] FN_FRQ_HI = 7'h1d;
   localparam logic [6:0] FN_FRQ_LO = 7'h1e;
   localparam logic [6:0] FN_HEAT   = 7'h45;
   // Timing: millisecond tick; preheat cycle in 100 ms steps of 1 %
   localparam int CLK_HZ        = 200_000_000;
   localparam int TICK_MS       = 1;
   localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_MS;
   localparam int HEAT_STEP_MS  = 100;
   localparam logic [6:0] HEAT_PERIOD_STEPS = 7'h64; // 10 s
endpackage

//--- src/dot_terminal.sv
// Drive output terminal logic: function select, comparators, counter, brake, preheat.
// Assumes drive state inputs are on sys_clk_i; terminal and card pins arrive asynchronously.

module dot_terminal #(
   parameter int TICK_CYC = dot_pkg::TICK_CYCLES
) (
   // Clock and reset
   input  wire logic        sys_clk_i,
   input  wire logic        reset_i,

   // Avalon-MM slave
   input  wire logic [7:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic      [31:0] avs_readdata_o,
   output logic             avs_waitrequest_o,

   // Drive state
   input  wire logic        run_i,
   input  wire logic        fault_i,
   input  wire logic        undervoltage_state_i,
   input  wire logic        fault_reset_i,
   input  wire logic        ext_run_cmd_i,
   input  wire logic        freq_from_terminal_i,
   input  wire logic [15:0] freq_cmd_i,
   input  wire logic [15:0] out_freq_i,
   input  wire logic [7:0]  out_current_i,

   // Pins and controller claims
   input  wire logic [15:0] configurable_input_i,
   input  wire logic [15:0] claimed_in_i,
   input  wire logic [15:0] claimed_out_i,
   input  wire logic [2:0]  card_code_i,

   // Outputs
   output logic      [15:0] terminal_o,
   output logic             auto_start_o,
   output logic             preheat_on_o,
   output logic      [6:0]  preheat_level_o
);

   // Settings
   logic [15:0] polarity_r, final_r, prelim_r, f1_r, f2_r, w1_r, w2_r, brake_dly_r;
   logic [15:0] bnd_r, heat_fn_in_r;
   logic [7:0]  cur_thr_r;
   logic [1:0]  ctl_r;
   logic [6:0]  lvl_r, cyc_r;
   logic [6:0]  func_r [16];
   // Counter, terminal state
   logic [15:0] count_r, held_r, logic_out_r;
   // Synchroniser stages
   logic [15:0] in_s1_r, in_s2_r, cl_i1_r, cl_i2_r, cl_o1_r, cl_o2_r, cnt_s1_r;
   logic [2:0]  card_s1_r, card_s2_r;
   // Event and preheat flags
   logic        cnt_s2_r, cnt_d_r, f_hit1_r, f_hit2_r, brake_r, final_hit_r, prelim_hit_r;
   logic        run_d_r, armed_r, settings_new_r, heat_r;
   // Divider and counters
   logic [31:0] tick_r;
   logic        tick_r1;
   logic [15:0] ms_r;
   logic [6:0]  heat_ms_r, step_r;
   // Bus side
   logic [15:0] rd_nxt;
   logic        wr, rd;

   // Single-cycle answer: one wait state, then waitrequest drops
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) avs_waitrequest_o <= 1'b1;
      else avs_waitrequest_o <= !((avs_read_i || avs_write_i) && avs_waitrequest_o);
   end
   // Writes land at the answer
   assign wr = avs_write_i && !avs_waitrequest_o;
   assign rd = avs_read_i && !avs_waitrequest_o;

   // Signal slice for a selected function code
   function automatic logic fn_val(input logic [6:0] code, input logic [15:0] src);
      case (code)
         dot_pkg::FN_FREQ1:  fn_val = src[0];
         dot_pkg::FN_FREQ2:  fn_val = src[1];
         dot_pkg::FN_BRAKE:  fn_val = src[2];
         dot_pkg::FN_PRELIM: fn_val = src[3];
         dot_pkg::FN_FINAL:  fn_val = src[4];
         dot_pkg::FN_CUR_HI: fn_val = src[5];
         dot_pkg::FN_CUR_LO: fn_val = src[6];
         dot_pkg::FN_FRQ_HI: fn_val = src[7];
         dot_pkg::FN_FRQ_LO: fn_val = src[8];
         dot_pkg::FN_HEAT:   fn_val = src[9];
         // Others stay inactive
         default:            fn_val = 1'b0;
      endcase
   endfunction

   // Software-written settings
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         polarity_r <= dot_pkg::RST_POLARITY;
         final_r <= dot_pkg::RST_FINAL_CNT;
         prelim_r <= dot_pkg::RST_ZERO;
         f1_r <= dot_pkg::RST_TGT_FREQ;
         f2_r <= dot_pkg::RST_TGT_FREQ;
         w1_r <= dot_pkg::RST_WIDTH;
         w2_r <= dot_pkg::RST_WIDTH;
         brake_dly_r <= dot_pkg::RST_ZERO;
         cur_thr_r <= 8'h00;
         bnd_r <= dot_pkg::RST_FREQ_BND;
         ctl_r <= 2'h0;
         lvl_r <= 7'h00;
         cyc_r <= 7'h00;
      // Lane 0 carries settings
      end else if (wr && avs_byteenable_i[0]) begin
         if (avs_address_i == dot_pkg::OFS_POLARITY)
            polarity_r <= avs_writedata_i[15:0] & ~dot_pkg::RESERVED_BITS;
         else if (avs_address_i == dot_pkg::OFS_FINAL_CNT && avs_writedata_i[15:0] != 16'h0000)
            final_r <= avs_writedata_i[15:0]; // Zero target refused
         else if (avs_address_i == dot_pkg::OFS_PRELIM_CNT) prelim_r <= avs_writedata_i[15:0];
         else if (avs_address_i == dot_pkg::OFS_TGT_FREQ1) f1_r <= avs_writedata_i[15:0];
         else if (avs_address_i == dot_pkg::OFS_TGT_FREQ2) f2_r <= avs_writedata_i[15:0];
         else if (avs_address_i == dot_pkg::OFS_WIDTH1) w1_r <= avs_writedata_i[15:0];
         else if (avs_address_i == dot_pkg::OFS_WIDTH2) w2_r <= avs_writedata_i[15:0];
         else if (avs_address_i == dot_pkg::OFS_BRAKE_DLY) brake_dly_r <= avs_writedata_i[15:0];
         else if (avs_address_i == dot_pkg::OFS_CUR_THR) cur_thr_r <= avs_writedata_i[7:0];
         else if (avs_address_i == dot_pkg::OFS_FREQ_BND) bnd_r <= avs_writedata_i[15:0];
         else if (avs_address_i == dot_pkg::OFS_CONTROL) ctl_r <= avs_writedata_i[1:0];
         else if (avs_address_i == dot_pkg::OFS_PREHEAT_LVL) lvl_r <= avs_writedata_i[6:0];
         else if (avs_address_i == dot_pkg::OFS_PREHEAT_CYC) cyc_r <= avs_writedata_i[6:0];
      end
   end

   // Function selector per terminal, plus input-side preheat command selectors
   // Selectors share the strobe
   generate
      for (genvar t = 0; t < 16; t++) begin : g_sel
         always_ff @(posedge sys_clk_i or posedge reset_i) begin
            if (reset_i) begin
               func_r[t] <= 7'h00;
               heat_fn_in_r[t] <= 1'b0;
            end else if (wr && avs_byteenable_i[0]
                         && avs_address_i == dot_pkg::OFS_FUNC_BASE + 8'(t * 4)) begin
               func_r[t] <= avs_writedata_i[6:0];
               heat_fn_in_r[t] <= avs_writedata_i[16]; // Input t carries function 69
            end
         end
      end
   endgenerate

   // Pin synchronisers
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         {in_s1_r, in_s2_r, cl_i1_r, cl_i2_r, cl_o1_r, cl_o2_r} <= '0;
         {card_s1_r, card_s2_r, cnt_s1_r, cnt_s2_r, cnt_d_r} <= '0;
      end else begin
         in_s1_r <= configurable_input_i;
         in_s2_r <= in_s1_r;
         cl_i1_r <= claimed_in_i;
         cl_i2_r <= cl_i1_r;
         cl_o1_r <= claimed_out_i;
         cl_o2_r <= cl_o1_r;
         card_s1_r <= card_code_i;
         card_s2_r <= card_s1_r;
         // Own stages for the edge
         cnt_s1_r <= configurable_input_i;
         cnt_s2_r <= cnt_s1_r[5]; // Sixth input is the counting input
         cnt_d_r <= cnt_s2_r;
      end
   end

   // Pulse counter: final clears, preliminary only flags
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         count_r <= 16'h0000;
         final_hit_r <= 1'b0;
         prelim_hit_r <= 1'b0;
      // Counting input rising edge
      end else if (cnt_s2_r && !cnt_d_r) begin
         if (count_r + 16'h0001 == final_r) begin
            count_r <= 16'h0000;
            final_hit_r <= 1'b1;
            prelim_hit_r <= 1'b0;
         end else begin
            count_r <= count_r + 16'h0001;
            final_hit_r <= 1'b0;
            if (count_r + 16'h0001 == prelim_r) prelim_hit_r <= 1'b1;
         end
      end
   end

   // Frequency-attained windows; terminal goes off once target band is entered
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         f_hit1_r <= 1'b0;
         f_hit2_r <= 1'b0;
      end else begin
         // 17 bits: no wrap at top
         f_hit1_r <= ({1'b0, out_freq_i} + {1'b0, w1_r} >= {1'b0, f1_r})
                     && ({1'b0, out_freq_i} <= {1'b0, f1_r} + {1'b0, w1_r});
         f_hit2_r <= ({1'b0, out_freq_i} + {1'b0, w2_r} >= {1'b0, f2_r})
                     && ({1'b0, out_freq_i} <= {1'b0, f2_r} + {1'b0, w2_r});
      end
   end

   // Millisecond tick divider
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         tick_r <= 32'h0;
         tick_r1 <= 1'b0;
      end else begin
         // Short in simulation
         tick_r1 <= (tick_r == 32'(TICK_CYC - 1));
         tick_r <= (tick_r == 32'(TICK_CYC - 1)) ? 32'h0 : tick_r + 32'h1;
      end
   end

   // Brake release after delay; only with DC braking enabled
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         ms_r <= 16'h0000;
         brake_r <= 1'b0;
      end else if (!run_i || !ctl_r[dot_pkg::CTL_DCBRAKE]) begin
         ms_r <= 16'h0000;
         brake_r <= 1'b0;
      // Delay restarts each run
      end else if (ms_r >= brake_dly_r) begin
         brake_r <= 1'b1;
      end else if (tick_r1) begin
         ms_r <= ms_r + 16'h0001;
      end
   end

   // Preheat arming: settings present at a stop arm it, late settings wait
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         run_d_r <= 1'b0;
         armed_r <= 1'b1; // Power-up counts as a stop
         settings_new_r <= 1'b0;
      end else begin
         run_d_r <= run_i;
         if (run_d_r && !run_i) begin
            armed_r <= 1'b1;
            settings_new_r <= 1'b0;
         end else if (wr && (avs_address_i == dot_pkg::OFS_PREHEAT_LVL
                             || avs_address_i == dot_pkg::OFS_PREHEAT_CYC) && !run_i) begin
            settings_new_r <= 1'b1;
            // Late write: next stop
            if (lvl_r == 7'h00 || cyc_r == 7'h00) armed_r <= 1'b0;
         end
      end
   end

   // Preheat duty cycle: off first, then on, ten-second period
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         heat_ms_r <= 7'h00;
         step_r <= 7'h00;
         heat_r <= 1'b0;
      end else begin
         // Input command wins over parameter arming; stop and no fault required
         if (lvl_r != 7'h00 && cyc_r != 7'h00 && !run_i && !fault_i
             && (|(in_s2_r & heat_fn_in_r) || (armed_r && !settings_new_r))) begin
            if (tick_r1) begin
               heat_ms_r <= (heat_ms_r == 7'(dot_pkg::HEAT_STEP_MS - 1)) ? 7'h00
                            : heat_ms_r + 7'h01;
               if (heat_ms_r == 7'(dot_pkg::HEAT_STEP_MS - 1))
                  step_r <= (step_r == dot_pkg::HEAT_PERIOD_STEPS - 7'h01) ? 7'h00
                            : step_r + 7'h01;
            end
            // Cycle over 100 unguarded
            heat_r <= (step_r >= dot_pkg::HEAT_PERIOD_STEPS - cyc_r);
         end else begin
            heat_ms_r <= 7'h00;
            step_r <= 7'h00;
            heat_r <= 1'b0;
         end
      end
   end

   // Logical function state per terminal, then polarity
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         logic_out_r <= 16'h0000;
         terminal_o <= 16'h0000;
      end else begin
         for (int t = 0; t < 16; t++)
            logic_out_r[t] <= fn_val(func_r[t], {6'h00, heat_r,
               out_freq_i < bnd_r, out_freq_i >= bnd_r,
               out_current_i < cur_thr_r, out_current_i >= cur_thr_r,
               final_hit_r, prelim_hit_r, !brake_r, !f_hit2_r, !f_hit1_r});
         // Readback is pre-polarity
         terminal_o <= (logic_out_r ^ polarity_r) & ~dot_pkg::RESERVED_BITS;
      end
   end

   // Preheat drive and auto-start; capture terminal frequency on fault or undervoltage
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) begin
         preheat_on_o <= 1'b0;
         preheat_level_o <= 7'h00;
         auto_start_o <= 1'b0;
         held_r <= 16'h0000;
      end else begin
         preheat_on_o <= heat_r && lvl_r != 7'h00; // Zero level stops it
         preheat_level_o <= heat_r ? lvl_r : 7'h00;
         // Level; sequencer starts
         auto_start_o <= ctl_r[dot_pkg::CTL_AUTOSTART] && ext_run_cmd_i
                         && !fault_i && (fault_reset_i || !run_d_r);
         if (freq_from_terminal_i && (fault_i || undervoltage_state_i))
            held_r <= freq_cmd_i;
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      rd_nxt = 16'h0000;
      if (avs_address_i == dot_pkg::OFS_POLARITY) rd_nxt = polarity_r;
      else if (avs_address_i == dot_pkg::OFS_FINAL_CNT) rd_nxt = final_r;
      else if (avs_address_i == dot_pkg::OFS_PRELIM_CNT) rd_nxt = prelim_r;
      else if (avs_address_i == dot_pkg::OFS_TGT_FREQ1) rd_nxt = f1_r;
      else if (avs_address_i == dot_pkg::OFS_TGT_FREQ2) rd_nxt = f2_r;
      else if (avs_address_i == dot_pkg::OFS_WIDTH1) rd_nxt = w1_r;
      else if (avs_address_i == dot_pkg::OFS_WIDTH2) rd_nxt = w2_r;
      else if (avs_address_i == dot_pkg::OFS_BRAKE_DLY) rd_nxt = brake_dly_r;
      else if (avs_address_i == dot_pkg::OFS_CUR_THR) rd_nxt = {8'h00, cur_thr_r};
      else if (avs_address_i == dot_pkg::OFS_FREQ_BND) rd_nxt = bnd_r;
      else if (avs_address_i == dot_pkg::OFS_CONTROL) rd_nxt = {14'h0000, ctl_r};
      else if (avs_address_i == dot_pkg::OFS_PREHEAT_LVL) rd_nxt = {9'h000, lvl_r};
      else if (avs_address_i == dot_pkg::OFS_PREHEAT_CYC) rd_nxt = {9'h000, cyc_r};
      // Status words
      else if (avs_address_i == dot_pkg::OFS_IN_STATE) rd_nxt = in_s2_r;
      else if (avs_address_i == dot_pkg::OFS_OUT_STATE) rd_nxt = logic_out_r;
      else if (avs_address_i == dot_pkg::OFS_CLAIM_IN) rd_nxt = cl_i2_r;
      else if (avs_address_i == dot_pkg::OFS_CLAIM_OUT) rd_nxt = cl_o2_r;
      else if (avs_address_i == dot_pkg::OFS_HELD_FREQ) rd_nxt = held_r;
      else if (avs_address_i == dot_pkg::OFS_CARD_ID) rd_nxt = {13'h0000, card_s2_r};
      else if (avs_address_i == dot_pkg::OFS_COUNT) rd_nxt = count_r;
   end

   // Read data register
   always_ff @(posedge sys_clk_i or posedge reset_i) begin
      if (reset_i) avs_readdata_o <= 32'h0;
      // Taken with the read
      else if (avs_read_i && avs_waitrequest_o) avs_readdata_o <= {16'h0000, rd_nxt};
   end
endmodule
